// File: bench/iebk_props.sv
// checker: port-level assertions for the enable bank
`timescale 1ns/1ps
`default_nettype none
module iebk_props
  import iebk_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [15:0] i_flags_1,
  input wire logic [15:0] i_flags_2,
  input wire logic [15:0] i_flags_3,
  input wire logic [15:0] i_flags_4,
  input wire logic [15:0] o_req_1,
  input wire logic [15:0] o_req_2,
  input wire logic [15:0] o_req_3,
  input wire logic [15:0] o_req_4,
  input wire logic o_any_req
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // a write shows on the gated requests right after its edge
  a_gate_b1: assert property (i_wr && i_addr == 4'h0 |=> o_req_1 == (i_flags_1 & $past(i_wdata) & IEBK_MASK_1))
    else $error("bank 1 gating wrong");
  a_gate_b2: assert property (i_wr && i_addr == 4'h1 |=> o_req_2 == (i_flags_2 & $past(i_wdata) & IEBK_MASK_2))
    else $error("bank 2 gating wrong");
  a_gate_b3: assert property (i_wr && i_addr == 4'h2 |=> o_req_3 == (i_flags_3 & $past(i_wdata) & IEBK_MASK_3))
    else $error("bank 3 gating wrong");
  a_gate_b4: assert property (i_wr && i_addr == 4'h3 |=> o_req_4 == (i_flags_4 & $past(i_wdata) & IEBK_MASK_4))
    else $error("bank 4 gating wrong");
  // no request without its flag, none on a hole in the map
  a_req_subset: assert property (((o_req_1 & ~(i_flags_1 & IEBK_MASK_1)) | (o_req_2 & ~(i_flags_2 & IEBK_MASK_2))
    | (o_req_3 & ~(i_flags_3 & IEBK_MASK_3)) | (o_req_4 & ~(i_flags_4 & IEBK_MASK_4))) == 16'h0) else $error("stray request");
  a_any_or: assert property (o_any_req == |{o_req_1, o_req_2, o_req_3, o_req_4}) else $error("summary wrong");
  a_rd_back: assert property (i_wr && i_addr == 4'h1 ##1 i_rd && !i_wr && i_addr == 4'h1 |=>
    o_rdata == ($past(i_wdata, 2) & IEBK_MASK_2)) else $error("readback wrong");
  a_rd_idle: assert property (!i_rd |=> o_rdata == 16'h0) else $error("read data without read");
  c_wr_b1: cover property (i_wr && i_addr == 4'h0);
  c_any: cover property (o_any_req);
  c_pend: cover property (i_rd && i_addr == IEBK_OFS_PEND_4);
endmodule : iebk_props
bind iebk_top iebk_props u_props (.*);
`default_nettype wire

// File: bench/iebk_src_model.sv
// model of the peripheral sources: level flags per bank
`timescale 1ns/1ps
`default_nettype none
module iebk_src_model
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [15:0] i_pat,
  output logic [15:0] o_flags_1,
  output logic [15:0] o_flags_2,
  output logic [15:0] o_flags_3,
  output logic [15:0] o_flags_4
);
  // registered like a real peripheral, so flags lag the command by a cycle
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst) {o_flags_1, o_flags_2, o_flags_3, o_flags_4} <= 64'h0;
    else {o_flags_1, o_flags_2, o_flags_3, o_flags_4} <= {4{i_pat}};
endmodule : iebk_src_model
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the interrupt enable bank
`timescale 1ns/1ps
`default_nettype none
module tb_top import iebk_pkg::*; ;
  logic i_clk_sys = 0, i_rst = 1, i_wr = 0, i_rd = 0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0, i_pat = 16'h0;
  wire logic [15:0] o_rdata, i_flags_1, i_flags_2, i_flags_3, i_flags_4, o_req_1, o_req_2, o_req_3, o_req_4;
  wire logic o_any_req;
  wire logic [63:0] req = {o_req_4, o_req_3, o_req_2, o_req_1};
  int n_mismatch = 0, check_count = 0;
  // rows: index, write data, flags; bank 3 row sets external inputs, assumed routed
  logic [35:0] rows [5] = '{{4'h0, 16'hffff, 16'hffff}, {4'h1, 16'hffff, 16'hc3a5}, {4'h2, 16'hffff, 16'hffff},
    {4'h3, 16'hffff, 16'h5a5a}, {4'h0, 16'h0000, 16'hffff}};
  iebk_top dut (.*);
  iebk_src_model u_src (.i_clk_sys, .i_rst, .i_pat, .o_flags_1(i_flags_1), .o_flags_2(i_flags_2),
    .o_flags_3(i_flags_3), .o_flags_4(i_flags_4));
  initial forever #12.5 i_clk_sys = ~i_clk_sys;
  // one bus cycle; back-to-back calls give strobes with no gap
  task automatic bus(input logic w, r, input logic [3:0] a, input logic [15:0] d);
    {i_wr, i_rd, i_addr, i_wdata} <= {w, r, a, d};
    @(posedge i_clk_sys);
    #1;
  endtask : bus
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] msk(input logic [3:0] a);
    return a == 0 ? IEBK_MASK_1 : a == 1 ? IEBK_MASK_2 : a == 2 ? IEBK_MASK_3 : a == 3 ? IEBK_MASK_4 : 16'h0;
  endfunction : msk
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // main sequence: table rows, then unmapped access and a mid-run reset
  initial
  begin
    logic [3:0] a;
    logic [15:0] d, f, e;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 0;
    #1;
    foreach (rows[k])
    begin
      {a, d, f} = rows[k];
      e = f & d & msk(a);
      i_pat <= f;
      bus(1, 0, a, d);
      chk(req[a*16 +: 16], e);
      bus(0, 1, a, 16'h0);
      chk(o_rdata, d & msk(a));
      bus(0, 1, a + 4'h4, 16'h0);
      chk(o_rdata, e);
    end
    bus(1, 0, 4'h9, 16'hffff);
    bus(0, 1, 4'h8, 16'h0);
    chk(o_rdata, 16'h0);
    chk({15'h0, o_any_req}, 16'h1);
    i_rst <= 1;
    bus(0, 0, 4'h0, 16'h0);
    i_rst <= 0;
    for (int i = 0; i < 4; i++)
    begin
      bus(0, 1, i[3:0], 16'h0);
      chk(o_rdata, 16'h0);
    end
    chk({15'h0, o_any_req}, 16'h0);
    wrap_up();
  end
  // watchdog: the sequence needs well under 100 cycles
  initial
  begin
    #5000;
    n_mismatch++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire

// File: hw/iebk_enable_reg.sv
// one 16-bit enable register with fixed implemented-bit mask
`timescale 1ns/1ps
`default_nettype none
module iebk_enable_reg
  import iebk_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK = 16'hffff
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_flags,
  output logic [15:0] o_value,
  output logic [15:0] o_req
);
  logic [15:0] en_r;
  logic [15:0] en_nxt;

  // unimplemented positions never store anything
  assign en_nxt = i_wr ? (i_wdata & IMPL_MASK) : en_r;

  // power-on clear, so every source starts disabled
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      en_r <= IEBK_RESET_VAL;
    end
    else
    begin
      en_r <= en_nxt;
    end
  end

  // mask is applied again on read so a stray bit can never leak
  assign o_value = en_r & IMPL_MASK;
  // gate: request only when flag and enable both set; flags never touched
  assign o_req = i_flags & en_r & IMPL_MASK;
endmodule : iebk_enable_reg
`default_nettype wire

// File: hw/iebk_pkg.sv
// package: register map, implemented-bit masks and reset values for the enable bank
package iebk_pkg;
  localparam int IEBK_NUM_REGS = 4;
  localparam int IEBK_DATA_W = 16;
  localparam int IEBK_ADDR_W = 4;
  // register offsets (word index on the plain register port)
  localparam logic [3:0] IEBK_OFS_BANK_1 = 4'h0;
  localparam logic [3:0] IEBK_OFS_BANK_2 = 4'h1;
  localparam logic [3:0] IEBK_OFS_BANK_3 = 4'h2;
  localparam logic [3:0] IEBK_OFS_BANK_4 = 4'h3;
  // status view of flag and enable per bank
  localparam logic [3:0] IEBK_OFS_PEND_1 = 4'h4;
  localparam logic [3:0] IEBK_OFS_PEND_4 = 4'h7;
  // implemented-bit masks
  localparam logic [15:0] IEBK_MASK_1 = 16'hfedf;
  localparam logic [15:0] IEBK_MASK_2 = 16'h3fe3;
  localparam logic [15:0] IEBK_MASK_3 = 16'h4066;
  localparam logic [15:0] IEBK_MASK_4 = 16'h210e;
  localparam logic [15:0] IEBK_RESET_VAL = 16'h0000;
  // bank 1 field positions
  localparam int IEBK_B1_UART_TWO_TRANSMIT_EN = 15;
  localparam int IEBK_B1_UART_TWO_RECEIVE_EN = 14;
  localparam int IEBK_B1_EXT_IRQ_TWO_EN = 13;
  localparam int IEBK_B1_TIMER_FIVE_EN = 12;
  localparam int IEBK_B1_TIMER_FOUR_EN = 11;
  localparam int IEBK_B1_OUT_COMPARE_FOUR_EN = 10;
  localparam int IEBK_B1_OUT_COMPARE_THREE_EN = 9;
  localparam int IEBK_B1_IN_CAPTURE_EIGHT_EN = 7;
  localparam int IEBK_B1_IN_CAPTURE_SEVEN_EN = 6;
  localparam int IEBK_B1_EXT_IRQ_ONE_EN = 4;
  localparam int IEBK_B1_CHANGE_NOTIFY_EN = 3;
  localparam int IEBK_B1_COMPARATOR_IRQ_EN = 2;
  localparam int IEBK_B1_I2C_ONE_MASTER_EN = 1;
  localparam int IEBK_B1_I2C_ONE_SLAVE_EN = 0;
  // bank 2 field positions
  localparam int IEBK_B2_PARALLEL_PORT_EN = 13;
  localparam int IEBK_B2_OUT_COMPARE_EIGHT_EN = 12;
  localparam int IEBK_B2_OUT_COMPARE_FIVE_EN = 9;
  localparam int IEBK_B2_IN_CAPTURE_SIX_EN = 8;
  localparam int IEBK_B2_IN_CAPTURE_THREE_EN = 5;
  localparam int IEBK_B2_SPI_TWO_EVENT_EN = 1;
  localparam int IEBK_B2_SPI_TWO_FAULT_EN = 0;
  // bank 3 field positions
  localparam int IEBK_B3_CALENDAR_CLOCK_EN = 14;
  localparam int IEBK_B3_EXT_IRQ_FOUR_EN = 6;
  localparam int IEBK_B3_EXT_IRQ_THREE_EN = 5;
  localparam int IEBK_B3_I2C_TWO_MASTER_EN = 2;
  localparam int IEBK_B3_I2C_TWO_SLAVE_EN = 1;
  // bank 4 field positions
  localparam int IEBK_B4_CHARGE_TIME_UNIT_EN = 13;
  localparam int IEBK_B4_LOW_VOLTAGE_DETECT_EN = 8;
  localparam int IEBK_B4_CRC_GENERATOR_EN = 3;
  localparam int IEBK_B4_UART_TWO_ERROR_EN = 2;
  localparam int IEBK_B4_UART_ONE_ERROR_EN = 1;
endpackage : iebk_pkg

// File: hw/iebk_top.sv
// interrupt enable bank 1 to 4: registers, request gating and register port
//
// How it works
// - enable bit one passes request, zero blocks
// - unimplemented bits read zero, ignore writes
// - implemented bits read/write, cleared at reset
// - bank 1 upper byte field layout
// - bank 1 lower byte field layout
// - bank 3 field layout
// - bank 4 field layout
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module iebk_top
  import iebk_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic [15:0] i_flags_1,
  input wire logic [15:0] i_flags_2,
  input wire logic [15:0] i_flags_3,
  input wire logic [15:0] i_flags_4,
  output logic [15:0] o_req_1,
  output logic [15:0] o_req_2,
  output logic [15:0] o_req_3,
  output logic [15:0] o_req_4,
  output logic o_any_req
);
  // masks per bank, held as a table indexed by bank number
  localparam logic [15:0] MASKS [4] = '{IEBK_MASK_1, IEBK_MASK_2, IEBK_MASK_3, IEBK_MASK_4};

  logic [15:0] flags [4];
  logic [15:0] value [4];
  logic [15:0] req [4];
  logic [3:0] wr_sel;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [15:0] rd_mux;
  logic [3:0] rd_en_sel;
  logic [3:0] rd_pend_sel;
  logic [15:0] view [4];

  // named enables, one per source, read straight out of the bank registers
  logic uart_two_transmit_en;
  logic uart_two_receive_en;
  logic ext_irq_two_en;
  logic timer_five_en;
  logic timer_four_en;
  logic out_compare_four_en;
  logic out_compare_three_en;
  logic in_capture_eight_en;
  logic in_capture_seven_en;
  logic ext_irq_one_en;
  logic change_notify_en;
  logic comparator_irq_en;
  logic i2c_one_master_en;
  logic i2c_one_slave_en;
  logic parallel_port_en;
  logic out_compare_eight_en;
  logic out_compare_seven_en;
  logic out_compare_six_en;
  logic out_compare_five_en;
  logic in_capture_six_en;
  logic in_capture_five_en;
  logic in_capture_four_en;
  logic in_capture_three_en;
  logic spi_two_event_en;
  logic spi_two_fault_en;
  logic calendar_clock_en;
  logic ext_irq_four_en;
  logic ext_irq_three_en;
  logic i2c_two_master_en;
  logic i2c_two_slave_en;
  logic charge_time_unit_en;
  logic low_voltage_detect_en;
  logic crc_generator_en;
  logic uart_two_error_en;
  logic uart_one_error_en;

  // one-hot hit of four consecutive indices from a base; shared by write and read decode
  function automatic logic [3:0] bank_onehot(input logic [3:0] idx, input logic [3:0] base);
    logic [3:0] hit;
    hit = 4'h0;
    for (int b = 0; b < 4; b++)
    begin
      hit[b] = (idx == (base + 4'(b)));
    end
    return hit;
  endfunction : bank_onehot

  // flags come from logic on the same clock, so no synchroniser
  assign flags[0] = i_flags_1;
  assign flags[1] = i_flags_2;
  assign flags[2] = i_flags_3;
  assign flags[3] = i_flags_4;

  // write decode: one-hot of the four enable offsets
  assign wr_sel = i_wr ? bank_onehot(i_addr, IEBK_OFS_BANK_1) : 4'h0;
  // read decode: enable views at the low indices, pending views above them
  assign rd_en_sel = bank_onehot(i_addr, IEBK_OFS_BANK_1);
  assign rd_pend_sel = bank_onehot(i_addr, IEBK_OFS_PEND_1);

  // one register per bank; masks fix the field layouts of each bank
  generate
    for (genvar g = 0; g < IEBK_NUM_REGS; g++)
    begin : g_bank
      iebk_enable_reg #(
        .IMPL_MASK(MASKS[g])
      ) u_reg (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_wr(wr_sel[g]),
        .i_wdata(i_wdata),
        .i_flags(flags[g]),
        .o_value(value[g]),
        .o_req(req[g])
      );
    end
  endgenerate

  // bank 1 fields; bits 8 and 5 are holes
  assign uart_two_transmit_en = value[0][IEBK_B1_UART_TWO_TRANSMIT_EN];
  assign uart_two_receive_en = value[0][IEBK_B1_UART_TWO_RECEIVE_EN];
  assign ext_irq_two_en = value[0][IEBK_B1_EXT_IRQ_TWO_EN];
  assign timer_five_en = value[0][IEBK_B1_TIMER_FIVE_EN];
  assign timer_four_en = value[0][IEBK_B1_TIMER_FOUR_EN];
  assign out_compare_four_en = value[0][IEBK_B1_OUT_COMPARE_FOUR_EN];
  assign out_compare_three_en = value[0][IEBK_B1_OUT_COMPARE_THREE_EN];
  assign in_capture_eight_en = value[0][IEBK_B1_IN_CAPTURE_EIGHT_EN];
  assign in_capture_seven_en = value[0][IEBK_B1_IN_CAPTURE_SEVEN_EN];
  assign ext_irq_one_en = value[0][IEBK_B1_EXT_IRQ_ONE_EN];
  assign change_notify_en = value[0][IEBK_B1_CHANGE_NOTIFY_EN];
  assign comparator_irq_en = value[0][IEBK_B1_COMPARATOR_IRQ_EN];
  assign i2c_one_master_en = value[0][IEBK_B1_I2C_ONE_MASTER_EN];
  assign i2c_one_slave_en = value[0][IEBK_B1_I2C_ONE_SLAVE_EN];

  // bank 2 fields; compare and capture channels sit in descending runs
  assign parallel_port_en = value[1][IEBK_B2_PARALLEL_PORT_EN];
  assign out_compare_eight_en = value[1][IEBK_B2_OUT_COMPARE_EIGHT_EN];
  assign out_compare_seven_en = value[1][IEBK_B2_OUT_COMPARE_FIVE_EN + 2];
  assign out_compare_six_en = value[1][IEBK_B2_OUT_COMPARE_FIVE_EN + 1];
  assign out_compare_five_en = value[1][IEBK_B2_OUT_COMPARE_FIVE_EN];
  assign in_capture_six_en = value[1][IEBK_B2_IN_CAPTURE_SIX_EN];
  assign in_capture_five_en = value[1][IEBK_B2_IN_CAPTURE_THREE_EN + 2];
  assign in_capture_four_en = value[1][IEBK_B2_IN_CAPTURE_THREE_EN + 1];
  assign in_capture_three_en = value[1][IEBK_B2_IN_CAPTURE_THREE_EN];
  assign spi_two_event_en = value[1][IEBK_B2_SPI_TWO_EVENT_EN];
  assign spi_two_fault_en = value[1][IEBK_B2_SPI_TWO_FAULT_EN];

  // bank 3 fields; external inputs still need routing by software
  assign calendar_clock_en = value[2][IEBK_B3_CALENDAR_CLOCK_EN];
  assign ext_irq_four_en = value[2][IEBK_B3_EXT_IRQ_FOUR_EN];
  assign ext_irq_three_en = value[2][IEBK_B3_EXT_IRQ_THREE_EN];
  assign i2c_two_master_en = value[2][IEBK_B3_I2C_TWO_MASTER_EN];
  assign i2c_two_slave_en = value[2][IEBK_B3_I2C_TWO_SLAVE_EN];

  // bank 4 fields
  assign charge_time_unit_en = value[3][IEBK_B4_CHARGE_TIME_UNIT_EN];
  assign low_voltage_detect_en = value[3][IEBK_B4_LOW_VOLTAGE_DETECT_EN];
  assign crc_generator_en = value[3][IEBK_B4_CRC_GENERATOR_EN];
  assign uart_two_error_en = value[3][IEBK_B4_UART_TWO_ERROR_EN];
  assign uart_one_error_en = value[3][IEBK_B4_UART_ONE_ERROR_EN];

  // read views rebuilt field by field, holes tied low so they always read zero
  assign view[0] = {uart_two_transmit_en, uart_two_receive_en, ext_irq_two_en, timer_five_en, timer_four_en,
    out_compare_four_en, out_compare_three_en, 1'h0, in_capture_eight_en, in_capture_seven_en, 1'h0,
    ext_irq_one_en, change_notify_en, comparator_irq_en, i2c_one_master_en, i2c_one_slave_en};
  assign view[1] = {2'h0, parallel_port_en, out_compare_eight_en, out_compare_seven_en, out_compare_six_en,
    out_compare_five_en, in_capture_six_en, in_capture_five_en, in_capture_four_en, in_capture_three_en,
    3'h0, spi_two_event_en, spi_two_fault_en};
  assign view[2] = {1'h0, calendar_clock_en, 7'h00, ext_irq_four_en, ext_irq_three_en, 2'h0,
    i2c_two_master_en, i2c_two_slave_en, 1'h0};
  assign view[3] = {2'h0, charge_time_unit_en, 4'h0, low_voltage_detect_en, 4'h0, crc_generator_en,
    uart_two_error_en, uart_one_error_en, 1'h0};

  // gated requests toward priority arbitration
  assign o_req_1 = req[0];
  assign o_req_2 = req[1];
  assign o_req_3 = req[2];
  assign o_req_4 = req[3];
  assign o_any_req = |{req[0], req[1], req[2], req[3]};

  // read mux; pending view lets software see flag-and-enable; unmapped reads zero
  // and-or select; the two decodes never hit together, so no priority is needed
  assign rd_mux = ({16{rd_en_sel[0]}} & view[0]) | ({16{rd_en_sel[1]}} & view[1])
    | ({16{rd_en_sel[2]}} & view[2]) | ({16{rd_en_sel[3]}} & view[3])
    | ({16{rd_pend_sel[0]}} & req[0]) | ({16{rd_pend_sel[1]}} & req[1])
    | ({16{rd_pend_sel[2]}} & req[2]) | ({16{rd_pend_sel[3]}} & req[3]);

  // read data stands only in the cycle after the strobe
  assign rdata_nxt = i_rd ? rd_mux : 16'h0000;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_r <= 16'h0000;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
endmodule : iebk_top
`default_nettype wire
